// ===== core/bbp_ctrl.sv
// Soft start, enable sequencing, limits, hiccup and register slave
`timescale 1ns/100ps
module bbp_ctrl #(
    parameter logic [6:0] I2C_ADDR   = bbp_pkg::I2C_ADDR_DEF,
    parameter int         ILIM_CYC   = bbp_pkg::ILIM_CYC,
    parameter int         HICCUP_CYC = bbp_pkg::HICCUP_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_above_reg_i,
    input  wire logic       en_above_high_i,
    input  wire logic       prebias_i,
    input  wire logic       pos_limit_trip_i,
    input  wire logic       neg_limit_trip_i,
    input  wire logic       latchoff_trip_i,
    input  wire logic       pwm_input_high_i,
    input  wire logic       pwm_input_low_i,
    input  wire logic       pwm_output_low_i,
    input  wire logic       pwm_output_high_i,
    input  wire logic [6:0] sense_out_first_i,
    input  wire logic [6:0] sense_out_second_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            regulator_on_o,
    output logic            input_high_switch_o,
    output logic            input_low_switch_o,
    output logic            output_low_switch_o,
    output logic            output_high_switch_o,
    output logic [7:0]      ref_code_o,
    output logic            cycle_start_o,
    output logic [1:0]      pos_limit_sel_o,
    output logic [1:0]      neg_limit_sel_o,
    output logic            latchoff_overcurrent_o
);

    // ==========================================================
    // Elaboration checks
    if (ILIM_CYC < 1 || ILIM_CYC >= 2 ** bbp_pkg::TMR_W) begin : g_chk_ilim
        $error("ILIM_CYC out of range");
    end
    if (HICCUP_CYC < 1 || HICCUP_CYC >= 2 ** bbp_pkg::TMR_W) begin : g_chk_hic
        $error("HICCUP_CYC out of range");
    end

    localparam logic [17:0] ILIM_TOP = 18'(ILIM_CYC - 1);
    localparam logic [17:0] HIC_TOP  = 18'(HICCUP_CYC - 1);

    // ==========================================================
    // State record
    typedef struct packed {
        bbp_pkg::bbp_conv_t st;
        logic [7:0]         ref_code;
        logic [8:0]         stp;
        logic [17:0]        tmr;
        logic               streak;
        logic               lim_seen;
        logic               plim;
        logic               nlim;
        logic               prebias;
        logic [7:0]         per;
        logic               cyc;
        logic [2:0]         fact;
        logic [7:0]         target;
        logic [1:0]         slew;
        logic [2:0]         freq;
        logic               dis;
        logic [1:0]         poslim;
        logic [1:0]         neglim;
        logic               latch_flag;
        logic [6:0]         adc1;
        logic [6:0]         adc2;
        bbp_pkg::bbp_i2c_t  ist;
        logic [7:0]         sh;
        logic [3:0]         cnt;
        logic [7:0]         ptr;
        logic               rw;
        logic               nack;
        logic               scl;
        logic               sda;
        logic               oe;
        logic               reg_on;
        logic [3:0]         sw;
    } bbp_state_t;

    localparam bbp_state_t S_RST = '{
        st: bbp_pkg::BBP_OFF, ist: bbp_pkg::BBP_I_IDLE,
        target: bbp_pkg::TARGET_RST, scl: 1'b1, sda: 1'b1, default: '0};

    bbp_state_t s_q;
    bbp_state_t s_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       i2c_start;
    logic       i2c_stop;
    logic [7:0] rdata_next;
    logic [8:0] step_top;
    logic       step_now;
    logic       active;
    logic       sw_on;

    // Register read view, unmapped offsets read as zero
    function automatic logic [7:0] rd_view(input bbp_state_t s,
                                           input logic [7:0] a);
        case (a)
            bbp_pkg::REG_TARGET: rd_view = s.target;
            bbp_pkg::REG_SLEW:   rd_view = {6'h00, s.slew};
            bbp_pkg::REG_FREQ:   rd_view = {5'h00, s.freq};
            bbp_pkg::REG_PROT:   rd_view = {6'h00, s.dis, 1'b0};
            bbp_pkg::REG_LIMIT:  rd_view = {2'h0, s.neglim, 2'h0, s.poslim};
            bbp_pkg::REG_STATUS: rd_view = {6'h00, s.st == bbp_pkg::BBP_HIC,
                                            s.latch_flag};
            bbp_pkg::REG_ADC1:   rd_view = {1'b0, s.adc1};
            bbp_pkg::REG_ADC2:   rd_view = {1'b0, s.adc2};
            default:             rd_view = 8'h00;
        endcase
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        s_d        = s_q;
        scl_rise   = scl_i & ~s_q.scl;
        scl_fall   = ~scl_i & s_q.scl;
        i2c_start  = s_q.scl & scl_i & s_q.sda & ~sda_i;
        i2c_stop   = s_q.scl & scl_i & ~s_q.sda & sda_i;
        rdata_next = rd_view(s_q, s_q.ptr);
        s_d.scl    = scl_i;
        s_d.sda    = sda_i;

        // Serial slave; only reachable while the regulator band holds
        if (i2c_start) begin
            s_d.ist = bbp_pkg::BBP_I_ADDR;
            s_d.cnt = 4'h0;
            s_d.oe  = 1'b0;
        end else if (i2c_stop) begin
            s_d.ist = bbp_pkg::BBP_I_IDLE;
            s_d.oe  = 1'b0;
        end else if (scl_rise) begin
            case (s_q.ist)
                bbp_pkg::BBP_I_ADDR, bbp_pkg::BBP_I_REG,
                bbp_pkg::BBP_I_WR: begin
                    s_d.sh  = {s_q.sh[6:0], sda_i};
                    s_d.cnt = s_q.cnt + 4'h1;
                end
                bbp_pkg::BBP_I_RD:   s_d.cnt  = s_q.cnt + 4'h1;
                bbp_pkg::BBP_I_MACK: s_d.nack = sda_i;
                default:             s_d.cnt  = s_q.cnt;
            endcase
        end else if (scl_fall) begin
            case (s_q.ist)
                bbp_pkg::BBP_I_ADDR: if (s_q.cnt == 4'h8) begin
                    if (s_q.sh[7:1] == I2C_ADDR) begin
                        s_d.oe  = 1'b1;
                        s_d.rw  = s_q.sh[0];
                        s_d.ist = bbp_pkg::BBP_I_AACK;
                    end else begin
                        s_d.ist = bbp_pkg::BBP_I_IDLE;
                    end
                end
                bbp_pkg::BBP_I_AACK, bbp_pkg::BBP_I_MACK: begin
                    s_d.cnt = 4'h0;
                    if (s_q.ist == bbp_pkg::BBP_I_MACK && s_q.nack) begin
                        s_d.oe  = 1'b0;
                        s_d.ist = bbp_pkg::BBP_I_IDLE;
                    end else if (s_q.ist == bbp_pkg::BBP_I_MACK || s_q.rw) begin
                        s_d.sh  = rdata_next;
                        s_d.oe  = ~rdata_next[7];
                        s_d.ist = bbp_pkg::BBP_I_RD;
                    end else begin
                        s_d.oe  = 1'b0;
                        s_d.ist = bbp_pkg::BBP_I_REG;
                    end
                end
                bbp_pkg::BBP_I_REG: if (s_q.cnt == 4'h8) begin
                    s_d.ptr = s_q.sh;
                    s_d.oe  = 1'b1;
                    s_d.ist = bbp_pkg::BBP_I_RACK;
                end
                bbp_pkg::BBP_I_RACK, bbp_pkg::BBP_I_WACK: begin
                    s_d.oe  = 1'b0;
                    s_d.cnt = 4'h0;
                    s_d.ist = bbp_pkg::BBP_I_WR;
                    if (s_q.ist == bbp_pkg::BBP_I_WACK) begin
                        s_d.ptr = s_q.ptr + 8'h01;
                    end
                end
                bbp_pkg::BBP_I_WR: if (s_q.cnt == 4'h8) begin
                    s_d.oe  = 1'b1;
                    s_d.ist = bbp_pkg::BBP_I_WACK;
                    case (s_q.ptr)
                        bbp_pkg::REG_TARGET: s_d.target = s_q.sh;
                        bbp_pkg::REG_SLEW:   s_d.slew   = s_q.sh[1:0];
                        bbp_pkg::REG_FREQ:   s_d.freq   = s_q.sh[2:0];
                        bbp_pkg::REG_PROT:
                            s_d.dis = s_q.sh[bbp_pkg::DIS_LATCH_BIT];
                        bbp_pkg::REG_LIMIT: begin
                            s_d.poslim = s_q.sh[1:0];
                            s_d.neglim = s_q.sh[bbp_pkg::NEG_LIM_LSB +: 2];
                        end
                        default: s_d.sh = s_q.sh;
                    endcase
                end
                bbp_pkg::BBP_I_RD: if (s_q.cnt == 4'h8) begin
                    s_d.oe  = 1'b0;
                    s_d.ptr = s_q.ptr + 8'h01;
                    s_d.ist = bbp_pkg::BBP_I_MACK;
                end else begin
                    s_d.sh = {s_q.sh[6:0], 1'b0};
                    s_d.oe = ~s_q.sh[6];
                end
                default: s_d.ist = bbp_pkg::BBP_I_IDLE;
            endcase
        end

        // Sense readout sampled every cycle
        s_d.adc1 = sense_out_first_i;
        s_d.adc2 = sense_out_second_i;

        // Reserved codes keep the last valid rate, no undefined period
        if (s_q.freq[2:1] != bbp_pkg::FREQ_BAD_HI) begin
            s_d.fact = s_q.freq;
        end

        // Switching cycle timer
        s_d.cyc = 1'b0;
        if (s_q.per == 8'h00) begin
            s_d.per = bbp_pkg::bbp_period(s_q.fact) - 8'h01;
            s_d.cyc = 1'b1;
        end else begin
            s_d.per = s_q.per - 8'h01;
        end

        // Cycle-by-cycle limits; a trip in the start cycle still wins
        s_d.plim = pos_limit_trip_i | (s_q.plim & ~s_d.cyc);
        s_d.nlim = neg_limit_trip_i | (s_q.nlim & ~s_d.cyc);
        if (s_d.cyc) begin
            s_d.streak   = s_q.lim_seen | pos_limit_trip_i;
            s_d.lim_seen = pos_limit_trip_i;
        end else begin
            s_d.lim_seen = s_q.lim_seen | pos_limit_trip_i;
        end

        // Reference step pacing from slew code
        step_top = bbp_pkg::STEP_TOP0 >> s_q.slew;
        step_now = (s_q.stp >= step_top);
        s_d.stp  = step_now ? 9'h000 : s_q.stp + 9'h001;

        // Conversion sequencing
        active = (s_q.st == bbp_pkg::BBP_SS) || (s_q.st == bbp_pkg::BBP_RUN)
              || (s_q.st == bbp_pkg::BBP_RDN);
        case (s_q.st)
            bbp_pkg::BBP_OFF: if (en_above_high_i) begin
                s_d.st         = bbp_pkg::BBP_SS;
                s_d.prebias    = prebias_i;
                s_d.ref_code   = 8'h00;
                s_d.latch_flag = 1'b0;
            end
            bbp_pkg::BBP_SS, bbp_pkg::BBP_RUN: begin
                if (step_now && s_q.ref_code < s_q.target) begin
                    s_d.ref_code = s_q.ref_code + 8'h01;
                end else if (step_now && s_q.ref_code > s_q.target) begin
                    s_d.ref_code = s_q.ref_code - 8'h01;
                end
                if (s_q.st == bbp_pkg::BBP_SS && s_q.ref_code == s_q.target) begin
                    s_d.st      = bbp_pkg::BBP_RUN;
                    s_d.prebias = 1'b0;
                end
                s_d.tmr = s_q.streak ? s_q.tmr + 18'h00001 : 18'h00000;
                if (s_q.streak && s_q.tmr >= ILIM_TOP) begin
                    s_d.st       = bbp_pkg::BBP_HIC;
                    s_d.tmr      = 18'h00000;
                    s_d.ref_code = 8'h00;
                    s_d.streak   = 1'b0;
                    s_d.lim_seen = 1'b0;
                end
                if (!en_above_high_i) begin
                    s_d.st = bbp_pkg::BBP_RDN;
                end
            end
            bbp_pkg::BBP_RDN: begin
                if (step_now && s_q.ref_code != 8'h00) begin
                    s_d.ref_code = s_q.ref_code - 8'h01;
                end
                if (en_above_high_i) begin
                    s_d.st      = bbp_pkg::BBP_SS;
                    s_d.prebias = prebias_i;
                end else if (s_q.ref_code == 8'h00) begin
                    s_d.st = bbp_pkg::BBP_OFF;
                end
            end
            bbp_pkg::BBP_HIC: begin
                s_d.tmr = s_q.tmr + 18'h00001;
                if (s_q.tmr >= HIC_TOP) begin
                    s_d.tmr = 18'h00000;
                    // Retry only once the short has gone away
                    if (!pos_limit_trip_i) begin
                        s_d.st      = bbp_pkg::BBP_SS;
                        s_d.prebias = prebias_i;
                    end
                end
                if (!en_above_high_i) begin
                    s_d.st = bbp_pkg::BBP_OFF;
                end
            end
            bbp_pkg::BBP_LAT: if (!en_above_high_i) begin
                s_d.st = bbp_pkg::BBP_OFF;
            end
            default: s_d.st = bbp_pkg::BBP_OFF;
        endcase

        // Latch-off overrides all but the low-band reset while switching
        if (active && latchoff_trip_i && !s_q.dis) begin
            s_d.st         = bbp_pkg::BBP_LAT;
            s_d.latch_flag = 1'b1;
        end

        // Gate drive, one register stage behind the modulator
        sw_on = (s_d.st == bbp_pkg::BBP_SS) || (s_d.st == bbp_pkg::BBP_RUN)
             || (s_d.st == bbp_pkg::BBP_RDN);
        s_d.sw[3]  = sw_on & pwm_input_high_i & ~s_d.plim;
        s_d.sw[2]  = sw_on & pwm_input_low_i & ~s_d.prebias;
        s_d.sw[1]  = sw_on & pwm_output_low_i;
        s_d.sw[0]  = sw_on & pwm_output_high_i & ~s_d.nlim;
        s_d.reg_on = 1'b1;

        // Lowest band: defaults everywhere, regulator off
        if (!en_above_reg_i) begin
            s_d = S_RST;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs straight from the state record, except sda_o which is tied low
    assign sda_o                  = 1'b0;
    assign sda_oe_o               = s_q.oe;
    assign regulator_on_o         = s_q.reg_on;
    assign input_high_switch_o    = s_q.sw[3];
    assign input_low_switch_o     = s_q.sw[2];
    assign output_low_switch_o    = s_q.sw[1];
    assign output_high_switch_o   = s_q.sw[0];
    assign ref_code_o             = s_q.ref_code;
    assign cycle_start_o          = s_q.cyc;
    assign pos_limit_sel_o        = s_q.poslim;
    assign neg_limit_sel_o        = s_q.neglim;
    assign latchoff_overcurrent_o = s_q.latch_flag;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_prebias_nonsync: assert property (
        (s_q.st == bbp_pkg::BBP_SS && s_q.prebias) |-> !input_low_switch_o)
        else $error("low switch on during prebiased start");
    a_ramp_spacing: assert property (
        ($changed(ref_code_o) && s_q.st == bbp_pkg::BBP_RUN
         && $past(s_q.st) == bbp_pkg::BBP_RUN)
        |=> $stable(ref_code_o) [*8])
        else $error("reference stepped too fast");
    a_mid_rampdown: assert property (
        (en_above_reg_i && !en_above_high_i && s_q.st == bbp_pkg::BBP_RUN
         && !latchoff_trip_i) |=> s_q.st == bbp_pkg::BBP_RDN)
        else $error("no ramp-down in middle band");
    a_low_defaults: assert property (
        !en_above_reg_i |=> !regulator_on_o && s_q.target ==
        bbp_pkg::TARGET_RST && s_q.freq == 3'h0 && !latchoff_overcurrent_o)
        else $error("defaults not restored in low band");
    a_freq_valid: assert property (
        (s_q.freq[2:1] != bbp_pkg::FREQ_BAD_HI) |=> s_q.fact == $past(s_q.freq))
        else $error("valid frequency not taken");
    a_freq_hold: assert property (
        (s_q.freq[2:1] == bbp_pkg::FREQ_BAD_HI) |=> $stable(s_q.fact))
        else $error("reserved frequency applied");
    a_adc_capture: assert property (
        en_above_reg_i |=> s_q.adc1 == $past(sense_out_first_i)
                           && s_q.adc2 == $past(sense_out_second_i))
        else $error("sense value not captured");
    a_pos_cut: assert property (
        pos_limit_trip_i |=> !input_high_switch_o)
        else $error("high switch on after positive trip");
    a_cycle_clear: assert property (
        (cycle_start_o && !$past(pos_limit_trip_i)) |-> !s_q.plim)
        else $error("limit not cleared at cycle start");
    a_hiccup_off: assert property (
        (s_q.st == bbp_pkg::BBP_HIC) |-> !input_high_switch_o
        && !input_low_switch_o && !output_low_switch_o && !output_high_switch_o)
        else $error("switch on during hiccup");
    a_latch_trip: assert property (
        (active && latchoff_trip_i && !s_q.dis && en_above_reg_i)
        |=> s_q.st == bbp_pkg::BBP_LAT && latchoff_overcurrent_o
            && !input_high_switch_o && !output_high_switch_o)
        else $error("latch-off not taken");
    a_latch_disabled: assert property (
        (s_q.dis && s_q.st != bbp_pkg::BBP_LAT) |=> s_q.st != bbp_pkg::BBP_LAT)
        else $error("latch-off taken while disabled");

endmodule

// ===== core/bbp_pkg.sv
// Package: register map, field layout, timing counts and state codes
package bbp_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_NS      = 50;
    localparam int CLK_KHZ     = 20000;
    localparam int STEP_UV     = 10000;   // One reference code at feedback
    localparam int SLEW0_UV_US = 600;     // Slowest slew, 0.6 mV/us
    localparam int STEP_CYC0   = STEP_UV * 1000 / (SLEW0_UV_US * CLK_NS);
    localparam logic [8:0] STEP_TOP0 = 9'(STEP_CYC0 - 1);
    localparam int ILIM_US     = 500;
    localparam int ILIM_CYC    = ILIM_US * 1000 / CLK_NS;
    localparam int HICCUP_MS   = 10;
    localparam int HICCUP_CYC  = HICCUP_MS * 1000000 / CLK_NS;
    localparam int TMR_W       = 18;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] REG_TARGET = 8'h01;
    localparam logic [7:0] REG_SLEW   = 8'h02;
    localparam logic [7:0] REG_FREQ   = 8'h03;
    localparam logic [7:0] REG_PROT   = 8'h04;
    localparam logic [7:0] REG_LIMIT  = 8'h05;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ADC1   = 8'h09;
    localparam logic [7:0] REG_ADC2   = 8'h0a;

    // ==========================================================
    // Fields and reset values
    localparam int DIS_LATCH_BIT = 1;
    localparam int NEG_LIM_LSB   = 4;
    localparam logic [7:0] TARGET_RST = 8'h32;
    localparam logic [1:0] FREQ_BAD_HI = 2'h3;   // Codes 110 and 111

    // ==========================================================
    // Switching periods per frequency code
    function automatic logic [7:0] bbp_period(input logic [2:0] code);
        case (code)
            3'h1:    bbp_period = 8'(CLK_KHZ / 150);
            3'h2:    bbp_period = 8'(CLK_KHZ / 300);
            3'h3:    bbp_period = 8'(CLK_KHZ / 450);
            3'h4:    bbp_period = 8'(CLK_KHZ / 750);
            3'h5:    bbp_period = 8'(CLK_KHZ / 900);
            default: bbp_period = 8'(CLK_KHZ / 600);
        endcase
    endfunction

    // ==========================================================
    // State codes
    typedef enum logic [2:0] {
        BBP_OFF = 3'h0, BBP_SS = 3'h1, BBP_RUN = 3'h2,
        BBP_RDN = 3'h3, BBP_HIC = 3'h4, BBP_LAT = 3'h5
    } bbp_conv_t;

    typedef enum logic [3:0] {
        BBP_I_IDLE = 4'h0, BBP_I_ADDR = 4'h1, BBP_I_AACK = 4'h2,
        BBP_I_REG  = 4'h3, BBP_I_RACK = 4'h4, BBP_I_WR   = 4'h5,
        BBP_I_WACK = 4'h6, BBP_I_RD   = 4'h7, BBP_I_MACK = 4'h8
    } bbp_i2c_t;

    localparam logic [6:0] I2C_ADDR_DEF = 7'h2c;  // Arbitrary value

endpackage

// ===== testbench/bbp_stage.sv
// Power stage model: switch requests per cycle and a shorted-load trip
`timescale 1ns/100ps
module bbp_stage (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic cyc_st_i,
    input  wire logic high_on_i,
    input  wire logic short_i,
    output logic      ih_o,
    output logic      il_o,
    output logic      ol_o,
    output logic      oh_o,
    output logic      trip_o
);
    logic [3:0] cnt_q;
    // ==========================================================
    // Phase counter restarts at every cycle start
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 4'h0;
        else if (cyc_st_i) cnt_q <= 4'h0;
        else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
    end
    // Buck phase; trips only while the high switch conducts
    assign ih_o = (cnt_q < 4'h8);
    assign il_o = ~ih_o;
    assign ol_o = 1'h0;
    assign oh_o = 1'h1;
    assign trip_o = short_i & high_on_i;
endmodule

// ===== testbench/bbp_ctrl_tb.sv
// Testbench: register access, soft start, hiccup, latch-off, enable bands
`timescale 1ns/100ps
module bbp_ctrl_tb;
    localparam logic [7:0] AW = {bbp_pkg::I2C_ADDR_DEF, 1'h0};
    localparam int HIC   = 100;
    localparam int ILIM  = 40;
    localparam int STEP3 = (bbp_pkg::STEP_TOP0 >> 3) + 1;  // Fastest slew
    logic clk = 0, rst_n = 0, reg_en = 0, hi_en = 0, scl = 1, sda_m = 1;
    logic short = 0, ltrip = 0, cs, ih, il, ol, oh, trp, oe, ron, lat;
    logic pb = 0, la = 0, ha = 0;
    logic hs_in, ls_in, ls_out, hs_out;
    logic [1:0] psel, nsel;
    logic [7:0] rv, refc;
    int error_cnt = 0, num_checks = 0, n;
    wire sda = sda_m & ~oe;   // Open drain data line
    always #25 clk = ~clk;
    bbp_ctrl #(.ILIM_CYC(ILIM), .HICCUP_CYC(HIC)) DUT (
        .sys_clk_i(clk), .rst_n_i(rst_n), .en_above_reg_i(reg_en),
        .en_above_high_i(hi_en), .prebias_i(pb), .pos_limit_trip_i(trp),
        .neg_limit_trip_i(1'h0), .latchoff_trip_i(ltrip),
        .pwm_input_high_i(ih), .pwm_input_low_i(il), .pwm_output_low_i(ol),
        .pwm_output_high_i(oh), .sense_out_first_i(7'h55),
        .sense_out_second_i(7'h2a), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(oe), .regulator_on_o(ron), .input_high_switch_o(hs_in),
        .input_low_switch_o(ls_in), .output_low_switch_o(ls_out),
        .output_high_switch_o(hs_out), .ref_code_o(refc),
        .cycle_start_o(cs), .pos_limit_sel_o(psel), .neg_limit_sel_o(nsel),
        .latchoff_overcurrent_o(lat));
    bbp_stage PM (.clk_i(clk), .rst_n_i(rst_n), .cyc_st_i(cs),
        .high_on_i(hs_in), .short_i(short), .ih_o(ih), .il_o(il),
        .ol_o(ol), .oh_o(oh), .trip_o(trp));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // Bus cycles: four clocks of SCL high and eight of SCL low per bit, slave sampled at SCL high
    task automatic bitx(input logic b, output logic r);
        sda_m <= b;
        cyc(4);
        scl <= 1'h1;
        cyc(4);
        r = sda;
        scl <= 1'h0;
        cyc(4);
    endtask
    task automatic byt(input logic [7:0] d, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(1'h1, a);   // Released: slave ACK, or master NACK
    endtask
    task automatic edge_sda(input logic lvl);
        sda_m <= ~lvl;
        cyc(4);
        scl <= 1'h1;
        cyc(4);
        sda_m <= lvl;
        cyc(4);
    endtask
    task automatic acc(input logic [7:0] a, d, input logic rd);
        edge_sda(1'h0);
        scl <= 1'h0;
        cyc(4);
        byt(AW, rv);
        byt(a, rv);
        if (rd) begin
            edge_sda(1'h0);
            scl <= 1'h0;
            cyc(4);
            byt(AW | 8'h01, rv);
            byt(8'hff, rv);
        end else byt(d, rv);
        edge_sda(1'h1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        acc(a, 8'h00, 1'h1);
        chk(rv, exp);
    endtask
    // Bounded wait for a reference code; cycles waited come back
    task automatic wref(input logic [7:0] v, output int k);
        for (k = 0; k < 3000 && refc !== v; k++) cyc(1);
    endtask
    // Cycles between two cycle-start pulses
    task automatic per(output int k);
        for (k = 0; k < 300 && !cs; k++) cyc(1);
        cyc(1);
        for (k = 1; k < 300 && !cs; k++) cyc(1);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        cyc(8);
        rst_n <= 1'h1;
        reg_en <= 1'h1;
        cyc(2);
        chk({7'h0, ron}, 8'h01);
        per(n);
        chk(n, bbp_pkg::CLK_KHZ / 600);
        rc(bbp_pkg::REG_LIMIT, 8'h00);
        rc(bbp_pkg::REG_ADC1, 8'h55);
        rc(bbp_pkg::REG_ADC2, 8'h2a);
        acc(bbp_pkg::REG_LIMIT, 8'h31, 1'h0);
        chk({4'h0, nsel, psel}, 8'h0d);
        acc(bbp_pkg::REG_SLEW, 8'h03, 1'h0);
        // Small target so the run state is reached quickly
        acc(bbp_pkg::REG_TARGET, 8'h03, 1'h0);
        hi_en <= 1'h1;
        wref(8'h01, n);
        wref(8'h02, n);
        chk(n, STEP3);
        wref(8'h03, n);
        // Rate change while switching, then a reserved code
        acc(bbp_pkg::REG_FREQ, 8'h01, 1'h0);
        per(n);
        chk(n, bbp_pkg::CLK_KHZ / 150);
        acc(bbp_pkg::REG_FREQ, 8'h06, 1'h0);
        per(n);
        chk(n, bbp_pkg::CLK_KHZ / 150);
        acc(bbp_pkg::REG_FREQ, 8'h00, 1'h0);
        acc(bbp_pkg::REG_TARGET, 8'h05, 1'h0);
        wref(8'h05, n);
        chk(refc, 8'h05);
        // Shorted load: wait for the stage to go dark, then time it
        short <= 1'h1;
        for (n = 0; n < 300 && hs_out; n++) cyc(1);
        short <= 1'h0;
        chk({hs_in, ls_in, ls_out, hs_out, refc[3:0]}, 8'h00);
        for (n = 0; n < 300 && !hs_out; n++) cyc(1);
        chk(n, HIC);
        wref(8'h05, n);
        chk(refc, 8'h05);
        hi_en <= 1'h0;
        wref(8'h00, n);
        chk({refc, 7'h0, n > 4 * STEP3}, 16'h0001);
        rc(bbp_pkg::REG_TARGET, 8'h05);
        hi_en <= 1'h1;
        acc(bbp_pkg::REG_PROT, 8'h02, 1'h0);
        ltrip <= 1'h1;
        cyc(3);
        chk({7'h0, lat}, 8'h00);
        acc(bbp_pkg::REG_PROT, 8'h00, 1'h0);
        cyc(3);
        ltrip <= 1'h0;
        cyc(2);
        chk({hs_in, ls_in, ls_out, hs_out, 3'h0, lat}, 8'h01);
        rc(bbp_pkg::REG_STATUS, 8'h01);
        hi_en <= 1'h0;   // Middle band first
        rc(bbp_pkg::REG_LIMIT, 8'h31);
        reg_en <= 1'h0;
        cyc(3);
        chk({7'h0, ron}, 8'h00);
        reg_en <= 1'h1;
        cyc(2);
        rc(bbp_pkg::REG_LIMIT, 8'h00);
        // Prebiased start: low input switch must stay off
        pb <= 1'h1;
        hi_en <= 1'h1;
        for (n = 0; n < 80; n++) begin
            cyc(1);
            la |= ls_in;
            ha |= hs_in;
        end
        chk({la, ha}, 8'h01);
        end_sim();
    end
    // Hang guard: counts as a mismatch
    initial begin
        cyc(90000);
        error_cnt++;
        end_sim();
    end
endmodule
